// [core/host_port_pin_select.sv]
// Host port pin selection, transmit-pending, wake, time pulse and amp enable
//
// Contract
// - With the select strap high or open the four shared pins carry serial TX/RX and two-wire clock/data.
// - With the strap low the shared pins form an SPI slave and serial and two-wire ports stay idle.
// - The transmit-pending indicator goes active at a set byte count, with selectable polarity.
// - Each transmit-pending indicator belongs to one port only and has its own pin.
// - The transmit-pending function is off after reset until it is enabled.
// - The serial bit rate is settable and starts at 9600 baud after reset.
// - The serial port has no flow-control lines and no clocked mode.
// - In power save any level change on the serial receive input wakes the receiver.
// - The time pulse follows the time grid with a settable interval, one per second after reset.
// - The event input is off after reset and once on may wake the receiver or mark time.
// - With the event input used for on/off switching its internal pull-up is turned off.
// - When not used as an input the event pin may carry the transmit-pending indication.
// - The amp enable is dropped in the OFF phase of on/off power save and in backup mode.
`timescale 1ns/1ps
module host_port_pin_select #(
   parameter int unsigned TP_PERIOD_RST = host_pin_pkg::TP_PERIOD_CYC
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic sel_strap_in,
   input wire logic pin_j5_i,
   output host_pin_pkg::pin_drive_t pin_j5,
   input wire logic pin_j4_i,
   output host_pin_pkg::pin_drive_t pin_j4,
   input wire logic pin_b1_i,
   output host_pin_pkg::pin_drive_t pin_b1,
   input wire logic pin_a2_i,
   output host_pin_pkg::pin_drive_t pin_a2,
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic [host_pin_pkg::DATA_W-1:0] tx_data,
   input wire logic [host_pin_pkg::BAUD_DIV_W-1:0] baud_div_in,
   input wire logic baud_div_load,
   output logic serial_rxd,
   input wire logic two_wire_scl_low,
   input wire logic two_wire_sda_low,
   output logic two_wire_scl,
   output logic two_wire_sda,
   input wire logic spi_miso,
   output logic spi_mosi,
   output logic spi_sclk,
   output logic spi_cs_n,
   output logic uart_mode,
   input wire host_pin_pkg::txr_cfg_t txr_cfg,
   output logic txr_pin,
   input wire logic power_save,
   input wire logic onoff_off_phase,
   input wire logic sw_backup,
   output logic wake,
   input wire logic grid_sync,
   input wire logic [host_pin_pkg::TP_W-1:0] tp_period_in,
   input wire logic tp_period_load,
   output logic time_grid_pulse,
   input wire host_pin_pkg::event_cfg_t event_cfg,
   input wire logic external_event_input_i,
   output host_pin_pkg::pin_drive_t external_event_input,
   output logic event_pullup_en,
   output logic event_mark,
   output logic external_amp_enable
);
   // ----------------------------------------------------------------
   // Strap capture
   // ----------------------------------------------------------------
   logic strap_done_ff;
   logic uart_mode_ff;

   // Caught one edge after release, never through the async reset
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         strap_done_ff <= 1'b0;
         uart_mode_ff <= host_pin_pkg::UART_MODE_RST;
      end else if (!strap_done_ff) begin
         strap_done_ff <= 1'b1;
         uart_mode_ff <= sel_strap_in;
      end
   end
   assign uart_mode = uart_mode_ff;

   // ----------------------------------------------------------------
   // Serial transmit path
   // ----------------------------------------------------------------
   logic [host_pin_pkg::BAUD_DIV_W-1:0] baud_div_ff;
   logic buf_valid;
   logic buf_ready;
   logic [host_pin_pkg::DATA_W-1:0] buf_data;
   logic [1:0] buf_fill;
   logic txd;
   logic tx_busy;
   logic tx_ready_w;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         baud_div_ff <= host_pin_pkg::BAUD_DIV_RST;
      end else if (baud_div_load && baud_div_in != '0) begin
         baud_div_ff <= baud_div_in;
      end
   end

   pair_buffer #(
      .W(host_pin_pkg::DATA_W)
   ) u_buf (
      .ref_clk(ref_clk),
      .rst(rst),
      .in_valid(tx_valid),
      .in_ready(tx_ready_w),
      .in_data(tx_data),
      .out_valid(buf_valid),
      .out_ready(buf_ready),
      .out_data(buf_data),
      .fill(buf_fill)
   );
   assign tx_ready = tx_ready_w;

   // Only data and ground, no handshake lines and no clocked mode
   serial_tx u_tx (
      .ref_clk(ref_clk),
      .rst(rst),
      .enable(uart_mode_ff && strap_done_ff),
      .baud_div(baud_div_ff),
      .in_valid(buf_valid),
      .in_ready(buf_ready),
      .in_data(buf_data),
      .txd(txd),
      .busy(tx_busy)
   );

   // ----------------------------------------------------------------
   // Shared pin routing
   // ----------------------------------------------------------------
   // Two-wire pins are open drain: enable only while pulling low
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pin_j5 <= '{o: 1'b1, oe: 1'b0};
         pin_j4 <= '{o: 1'b1, oe: 1'b0};
         pin_b1 <= '{o: 1'b1, oe: 1'b0};
         pin_a2 <= '{o: 1'b1, oe: 1'b0};
      end else if (!strap_done_ff) begin
         // Nothing driven before the strap is known, so no wrong driver on a shared line
         pin_j5 <= '{o: 1'b1, oe: 1'b0};
         pin_j4 <= '{o: 1'b1, oe: 1'b0};
         pin_b1 <= '{o: 1'b1, oe: 1'b0};
         pin_a2 <= '{o: 1'b1, oe: 1'b0};
      end else if (uart_mode_ff) begin
         pin_j5 <= '{o: txd, oe: 1'b1};
         pin_j4 <= '{o: 1'b1, oe: 1'b0};
         pin_b1 <= '{o: 1'b0, oe: two_wire_scl_low};
         pin_a2 <= '{o: 1'b0, oe: two_wire_sda_low};
      end else begin
         // MISO released while deselected so a shared bus stays free
         pin_j5 <= '{o: spi_miso, oe: !pin_a2_i};
         pin_j4 <= '{o: 1'b1, oe: 1'b0};
         pin_b1 <= '{o: 1'b1, oe: 1'b0};
         pin_a2 <= '{o: 1'b1, oe: 1'b0};
      end
   end

   // Engines of the unmapped ports see idle levels only
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         serial_rxd <= 1'b1;
         two_wire_scl <= 1'b1;
         two_wire_sda <= 1'b1;
         spi_mosi <= 1'b0;
         spi_sclk <= 1'b0;
         spi_cs_n <= 1'b1;
      end else if (!strap_done_ff) begin
         // Idle levels until the strap is known, so no engine sees a stray bit
         serial_rxd <= 1'b1;
         two_wire_scl <= 1'b1;
         two_wire_sda <= 1'b1;
         spi_mosi <= 1'b0;
         spi_sclk <= 1'b0;
         spi_cs_n <= 1'b1;
      end else begin
         serial_rxd <= uart_mode_ff ? pin_j4_i : 1'b1;
         two_wire_scl <= uart_mode_ff ? pin_b1_i : 1'b1;
         two_wire_sda <= uart_mode_ff ? pin_a2_i : 1'b1;
         spi_mosi <= uart_mode_ff ? 1'b0 : pin_j4_i;
         spi_sclk <= uart_mode_ff ? 1'b0 : pin_b1_i;
         spi_cs_n <= uart_mode_ff ? 1'b1 : pin_a2_i;
      end
   end

   // ----------------------------------------------------------------
   // Transmit-pending indicator
   // ----------------------------------------------------------------
   logic [host_pin_pkg::PEND_W-1:0] pend_cnt;
   logic pend_hit;

   // Counts only this port's bytes: the indicator is never shared
   assign pend_cnt = host_pin_pkg::PEND_W'(buf_fill) + host_pin_pkg::PEND_W'(tx_busy);
   assign pend_hit = txr_cfg.txr_en && (pend_cnt >= txr_cfg.txr_threshold) &&
                     (txr_cfg.txr_threshold != '0);

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         txr_pin <= 1'b0;
      end else begin
         txr_pin <= txr_cfg.txr_active_low ? !pend_hit : pend_hit;
      end
   end

   // ----------------------------------------------------------------
   // Receive-line and event wake-up
   // ----------------------------------------------------------------
   logic rxd_last_ff;
   logic ev_last_ff;
   logic ev_edge;
   logic rxd_edge;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rxd_last_ff <= 1'b1;
         ev_last_ff <= 1'b1;
      end else begin
         rxd_last_ff <= serial_rxd;
         ev_last_ff <= external_event_input_i;
      end
   end

   assign rxd_edge = uart_mode_ff && (serial_rxd != rxd_last_ff);
   assign ev_edge = event_cfg.en && (external_event_input_i != ev_last_ff);

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wake <= 1'b0;
         event_mark <= 1'b0;
      end else begin
         // Either edge counts; a glitch on an idle line also wakes
         wake <= power_save && (rxd_edge || (ev_edge && event_cfg.wake));
         event_mark <= ev_edge && external_event_input_i && !event_cfg.wake;
      end
   end

   // ----------------------------------------------------------------
   // Event pin drive and pull-up
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         external_event_input <= '{o: 1'b0, oe: 1'b0};
         event_pullup_en <= 1'b1;
      end else begin
         // Host must drive the pin whenever the pull-up is dropped
         event_pullup_en <= !(event_cfg.en && event_cfg.onoff);
         if (!event_cfg.en && txr_cfg.txr_on_event) begin
            external_event_input <= '{o: txr_pin, oe: 1'b1};
         end else begin
            external_event_input <= '{o: 1'b0, oe: 1'b0};
         end
      end
   end

   // ----------------------------------------------------------------
   // Time-grid pulse
   // ----------------------------------------------------------------
   logic [host_pin_pkg::TP_W-1:0] tp_period_ff;
   logic [host_pin_pkg::TP_W-1:0] tp_cnt_ff;
   logic [host_pin_pkg::TP_W-1:0] nxt_tp_cnt;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         tp_period_ff <= host_pin_pkg::TP_W'(TP_PERIOD_RST);
      end else if (tp_period_load && tp_period_in > 1) begin
         tp_period_ff <= tp_period_in;
      end
   end

   // Pulse follows the next count, so the wrap cycle belongs to the first half
   always_comb begin
      if (grid_sync || tp_cnt_ff >= tp_period_ff - 1'b1) begin
         nxt_tp_cnt = '0;
      end else begin
         nxt_tp_cnt = tp_cnt_ff + 1'b1;
      end
   end

   // High for the first half of each interval, restarted on grid marks
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         tp_cnt_ff <= '0;
         time_grid_pulse <= 1'b0;
      end else begin
         tp_cnt_ff <= nxt_tp_cnt;
         time_grid_pulse <= nxt_tp_cnt < (tp_period_ff >> 1);
      end
   end

   // ----------------------------------------------------------------
   // External amplifier enable
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         external_amp_enable <= 1'b0;
      end else begin
         external_amp_enable <= !(onoff_off_phase || sw_backup);
      end
   end
endmodule

// [core/host_pin_pkg.sv]
// Shared constants and carriers for the host port pin selection block
package host_pin_pkg;
   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned BAUD_DEFAULT = 9600;
   localparam int unsigned BAUD_DIV_W = 16;
   localparam logic [BAUD_DIV_W-1:0] BAUD_DIV_RST = BAUD_DIV_W'(CLK_HZ / BAUD_DEFAULT);
   localparam int unsigned TP_PERIOD_S = 1;
   localparam int unsigned TP_PERIOD_CYC = CLK_HZ * TP_PERIOD_S;
   localparam int unsigned TP_W = 32;
   // ----------------------------------------------------------------
   // Frame and buffer layout
   // ----------------------------------------------------------------
   localparam int unsigned DATA_W = 8;
   localparam int unsigned FRAME_BITS = 10;
   localparam int unsigned FILL_W = 2;
   localparam int unsigned PEND_W = 3;
   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic UART_MODE_RST = 1'b1;
   localparam logic TXR_EN_RST = 1'b0;
   localparam logic EVENT_EN_RST = 1'b0;
   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic o;
      logic oe;
   } pin_drive_t;
   typedef struct packed {
      logic txr_en;
      logic txr_active_low;
      logic [PEND_W-1:0] txr_threshold;
      logic txr_on_event;
   } txr_cfg_t;
   typedef struct packed {
      logic en;
      logic onoff;
      logic wake;
   } event_cfg_t;
endpackage

// [core/pair_buffer.sv]
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module pair_buffer #(
   parameter int unsigned W = 8
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data,
   output logic [1:0] fill
);
   logic [W-1:0] mem_ff [2];
   logic wr_ptr_ff;
   logic rd_ptr_ff;
   logic [1:0] cnt_ff;
   logic push;
   logic pop;

   assign in_ready = (cnt_ff != 2'h2);
   assign out_valid = (cnt_ff != 2'h0);
   assign out_data = mem_ff[rd_ptr_ff];
   assign fill = cnt_ff;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem_ff[wr_ptr_ff] <= in_data;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wr_ptr_ff <= 1'b0;
         rd_ptr_ff <= 1'b0;
         cnt_ff <= 2'h0;
      end else begin
         if (push) begin
            wr_ptr_ff <= ~wr_ptr_ff;
         end
         if (pop) begin
            rd_ptr_ff <= ~rd_ptr_ff;
         end
         cnt_ff <= 2'(cnt_ff + {1'b0, push} - {1'b0, pop});
      end
   end
endmodule

// [core/serial_tx.sv]
// Asynchronous serial transmitter, 8N1, no flow control
`timescale 1ns/1ps
module serial_tx (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic enable,
   input wire logic [host_pin_pkg::BAUD_DIV_W-1:0] baud_div,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [host_pin_pkg::DATA_W-1:0] in_data,
   output logic txd,
   output logic busy
);
   typedef enum logic {IDLE, SHIFT} tx_state_t;
   tx_state_t state_ff;
   logic [host_pin_pkg::FRAME_BITS-1:0] shift_ff;
   logic [3:0] bits_ff;
   logic [host_pin_pkg::BAUD_DIV_W-1:0] tick_ff;

   // Held off while the port is unmapped, so the feeding buffer stalls
   assign in_ready = enable && (state_ff == IDLE);
   assign txd = shift_ff[0];
   assign busy = (state_ff == SHIFT);

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_ff <= IDLE;
         shift_ff <= '1;
         bits_ff <= 4'h0;
         tick_ff <= '0;
      end else begin
         unique case (state_ff)
            IDLE: begin
               if (in_valid && in_ready) begin
                  shift_ff <= {1'b1, in_data, 1'b0};
                  bits_ff <= 4'(host_pin_pkg::FRAME_BITS - 1);
                  tick_ff <= baud_div;
                  state_ff <= SHIFT;
               end
            end
            SHIFT: begin
               if (tick_ff > 1) begin
                  tick_ff <= tick_ff - 1'b1;
               end else begin
                  tick_ff <= baud_div;
                  shift_ff <= {1'b1, shift_ff[host_pin_pkg::FRAME_BITS-1:1]};
                  if (bits_ff == 4'h0) begin
                     state_ff <= IDLE;
                  end else begin
                     bits_ff <= bits_ff - 4'h1;
                  end
               end
            end
         endcase
      end
   end
endmodule

// [tb/host_pin_monitor.sv]
// Concurrent checks on the host port pin selection block
`timescale 1ns/1ps
module host_pin_monitor (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic pin_j4_i,
   input wire host_pin_pkg::pin_drive_t pin_j5,
   input wire host_pin_pkg::pin_drive_t pin_j4,
   input wire host_pin_pkg::pin_drive_t pin_b1,
   input wire host_pin_pkg::pin_drive_t pin_a2,
   input wire logic serial_rxd,
   input wire logic two_wire_scl_low,
   input wire logic uart_mode,
   input wire host_pin_pkg::txr_cfg_t txr_cfg,
   input wire logic txr_pin,
   input wire logic power_save,
   input wire logic onoff_off_phase,
   input wire logic sw_backup,
   input wire logic wake,
   input wire logic grid_sync,
   input wire logic time_grid_pulse,
   input wire host_pin_pkg::event_cfg_t event_cfg,
   input wire host_pin_pkg::pin_drive_t external_event_input,
   input wire logic event_pullup_en,
   input wire logic event_mark,
   input wire logic external_amp_enable
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // ----------------------------------------------------------------
   // Sequences
   // ----------------------------------------------------------------
   // Three cycles so the registered pins have caught up with the mode
   sequence s_uart; uart_mode [*3]; endsequence
   sequence s_spi; !uart_mode [*3]; endsequence
   sequence s_rx_edge; $changed(pin_j4_i) && uart_mode ##1 power_save; endsequence
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   a_mode_fixed: assert property (!rst ##1 !rst |=> $stable(uart_mode))
      else $error("pin mode moved after start");
   a_uart_pins: assert property (s_uart |-> pin_j5.oe && !pin_j4.oe)
      else $error("serial pin directions wrong");
   a_drain_low: assert property (s_uart ##0 two_wire_scl_low |=> pin_b1.oe && !pin_b1.o)
      else $error("two-wire clock not pulled low");
   a_spi_quiet: assert property (s_spi |-> !pin_j4.oe && !pin_b1.oe && !pin_a2.oe && serial_rxd)
      else $error("serial side active in SPI mode");
   a_txr_idle: assert property (!txr_cfg.txr_en |=> txr_pin == $past(txr_cfg.txr_active_low))
      else $error("pending pin active while off");
   a_wake_rx: assert property (s_rx_edge |=> wake)
      else $error("no wake on receive edge");
   a_amp_off: assert property (onoff_off_phase || sw_backup |=> !external_amp_enable)
      else $error("amp enable left on");
   a_pullup_off: assert property (event_cfg.en && event_cfg.onoff |=> !event_pullup_en)
      else $error("event pull-up left on");
   a_event_quiet: assert property (!event_cfg.en |=> !event_mark)
      else $error("event mark while disabled");
   a_grid_mark: assert property (grid_sync |=> time_grid_pulse)
      else $error("no pulse on grid mark");
   a_event_txr: assert property (!event_cfg.en && txr_cfg.txr_on_event
      |=> external_event_input.oe && external_event_input.o == $past(txr_pin))
      else $error("event pin not carrying pending level");
endmodule
bind host_port_pin_select host_pin_monitor mon (
   .ref_clk, .rst, .pin_j4_i, .pin_j5, .pin_j4, .pin_b1, .pin_a2, .serial_rxd,
   .two_wire_scl_low, .uart_mode, .txr_cfg, .txr_pin, .power_save, .onoff_off_phase,
   .sw_backup, .wake, .grid_sync, .time_grid_pulse, .event_cfg, .external_event_input,
   .event_pullup_en, .event_mark, .external_amp_enable
);

// [tb/host_serial_model.sv]
// Host side serial receiver model, 8N1
// No flash on this link; firmware store size is a board matter
`timescale 1ns/1ps
module host_serial_model (
   input wire logic ref_clk,
   input wire logic enable,
   input wire logic [15:0] div,
   input wire logic txd
);
   logic [7:0] q[$];
   logic [7:0] sh;
   int n_frame_err = 0;
   // ----------------------------------------------------------------
   // Frame decode
   // ----------------------------------------------------------------
   // No handshake lines, so the host can never hold the sender off
   always begin
      @(negedge txd iff enable);
      repeat (div / 2) @(posedge ref_clk);
      for (int i = 0; i < 8; i++) begin
         repeat (div) @(posedge ref_clk);
         sh[i] = txd;
      end
      repeat (div) @(posedge ref_clk);
      if (txd !== 1'b1) n_frame_err++;
      q.push_back(sh);
   end
endmodule

// [tb/host_port_pin_select_test.sv]
// Self-checking bench for the host port pin selection block
`timescale 1ns/1ps
module host_port_pin_select_test;
   localparam int TP = 20;
   localparam logic [15:0] DIV = 16'h0010;
   logic ref_clk = 0, rst = 1, sel_strap_in = 1, pin_j4_i = 1, tx_valid = 0;
   logic baud_div_load = 0, two_wire_scl_low = 0, two_wire_sda_low = 0, spi_miso = 0;
   logic power_save = 0, onoff_off_phase = 0, sw_backup = 0, grid_sync = 0;
   logic tp_period_load = 0, external_event_input_i = 1, b1_h = 1, a2_h = 1, mdl_en = 0;
   logic [7:0] tx_data = 8'h00;
   logic [15:0] baud_div_in = 16'h0000;
   logic [31:0] tp_period_in = 32'h0000_0000;
   host_pin_pkg::txr_cfg_t txr_cfg = '0;
   host_pin_pkg::event_cfg_t event_cfg = '0;
   host_pin_pkg::pin_drive_t pin_j5, pin_j4, pin_b1, pin_a2, external_event_input;
   logic tx_ready, serial_rxd, two_wire_scl, two_wire_sda, spi_mosi, spi_sclk, spi_cs_n;
   logic uart_mode, txr_pin, wake, time_grid_pulse, event_pullup_en, event_mark;
   logic external_amp_enable;
   // Released lines sit at the pull-up or at the host's level
   wire pin_j5_i = pin_j5.oe ? pin_j5.o : 1'b1;
   wire pin_b1_i = pin_b1.oe ? pin_b1.o : b1_h;
   wire pin_a2_i = pin_a2.oe ? pin_a2.o : a2_h;
   int n_fail = 0, compares = 0, cyc = 0, seed = 32'h4760, n, r;
   logic [7:0] sent[$];
   host_port_pin_select #(.TP_PERIOD_RST(TP)) dut (.*);
   host_serial_model host (.ref_clk(ref_clk), .enable(mdl_en), .div(DIV), .txd(pin_j5_i));
   always #5 ref_clk = ~ref_clk;
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up;
      $display("Compares %0d, mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   function automatic logic exp_txr(input int pend, input host_pin_pkg::txr_cfg_t c);
      logic act;
      act = c.txr_en && c.txr_threshold != 3'h0 && pend >= c.txr_threshold;
      return act ^ c.txr_active_low;
   endfunction
   task automatic do_reset(input logic strap);
      rst = 1;
      sel_strap_in = strap;
      repeat (5) @(negedge ref_clk);
      rst = 0;
      repeat (2) @(negedge ref_clk);
   endtask
   // Leaves valid up so back-to-back calls never lower and raise it at once
   task automatic send(input logic [7:0] b, input int lim, output logic ok);
      int k;
      k = 0;
      tx_valid = 1;
      tx_data = b;
      while (tx_ready !== 1'b1 && k < lim) begin
         k++;
         @(negedge ref_clk);
      end
      ok = (tx_ready === 1'b1);
      @(negedge ref_clk);
   endtask
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 40000) begin
         n_fail++;
         wrap_up();
      end
   end
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      logic ok;
      logic [7:0] b;
      logic amp_x, pu_x;
      do_reset(1'b1);
      check(uart_mode, 1);
      // Only the start bit is timed at the default rate, to keep the run short
      send(8'hff, 10, ok);
      tx_valid = 0;
      n = 0;
      while (pin_j5.o === 1'b1 && n < 50) begin
         n++;
         @(negedge ref_clk);
      end
      n = 0;
      while (pin_j5.o === 1'b0 && n < 20000) begin
         n++;
         @(negedge ref_clk);
      end
      check(n, host_pin_pkg::BAUD_DIV_RST);
      do_reset(1'b1);
      check(txr_pin, 0);
      baud_div_in = DIV;
      baud_div_load = 1;
      @(negedge ref_clk);
      baud_div_load = 0;
      mdl_en = 1;
      r = $random(seed);
      txr_cfg.txr_en = 1;
      txr_cfg.txr_active_low = r[0];
      txr_cfg.txr_threshold = (r[5:4] == 2'h0) ? 3'h3 : {1'b0, r[5:4]};
      txr_cfg.txr_on_event = 1;
      for (int i = 0; i < 4; i++) begin
         b = (i == 0) ? 8'h00 : (i == 3) ? 8'hff : 8'($random(seed));
         sent.push_back(b);
         send(b, 400, ok);
         check(ok, 1);
      end
      tx_valid = 0;
      @(negedge ref_clk);
      check(txr_pin, exp_txr(3, txr_cfg));
      n = 0;
      while (txr_pin !== exp_txr(0, txr_cfg) && n < 2000) begin
         n++;
         @(negedge ref_clk);
      end
      check(n < 2000, 1);
      n = 0;
      while (host.q.size() < 4 && n < 500) begin
         n++;
         @(negedge ref_clk);
      end
      check(host.q.size(), 4);
      foreach (sent[i]) check(host.q[i], sent[i]);
      check(host.n_frame_err, 0);
      for (int p = 1; p >= 0; p--) begin
         power_save = p[0];
         pin_j4_i = ~pin_j4_i;
         n = 0;
         repeat (6) begin
            @(negedge ref_clk);
            n += (wake !== 1'b0);
         end
         check(n, p);
      end
      check(serial_rxd, pin_j4_i);
      for (int i = 0; i < 300; i++) begin
         r = $random(seed);
         {onoff_off_phase, sw_backup, two_wire_scl_low, two_wire_sda_low} = r[3:0];
         {power_save, pin_j4_i, external_event_input_i} = r[6:4];
         event_cfg = host_pin_pkg::event_cfg_t'(r[9:7]);
         txr_cfg.txr_on_event = r[10];
         grid_sync = (r[15:11] == 5'h00);
         amp_x = !(r[3] || r[2]);
         pu_x = !(r[9] && r[8]);
         @(negedge ref_clk);
         check(external_amp_enable, amp_x);
         check(event_pullup_en, pu_x);
      end
      grid_sync = 0;
      two_wire_scl_low = 1;
      two_wire_sda_low = 0;
      repeat (25) @(negedge ref_clk);
      n = 0;
      repeat (100) begin
         @(negedge ref_clk);
         n += (time_grid_pulse === 1'b1);
      end
      check(n, 50);
      check({two_wire_scl, two_wire_sda}, 2'b01);
      tp_period_in = 32'h0000_000a;
      tp_period_load = 1;
      @(negedge ref_clk);
      tp_period_load = 0;
      repeat (25) @(negedge ref_clk);
      n = 0;
      b[0] = time_grid_pulse;
      repeat (100) begin
         @(negedge ref_clk);
         n += (time_grid_pulse === 1'b1 && b[0] === 1'b0);
         b[0] = time_grid_pulse;
      end
      check(n, 10);
      mdl_en = 0;
      do_reset(1'b0);
      check(uart_mode, 0);
      sel_strap_in = 1;
      repeat (3) @(negedge ref_clk);
      check(uart_mode, 0);
      n = 0;
      repeat (4) begin
         send(8'ha5, 3, ok);
         n += ok;
      end
      tx_valid = 0;
      check(n, 2);
      r = $random(seed);
      a2_h = 0;
      b1_h = r[2];
      spi_miso = r[0];
      pin_j4_i = r[1];
      repeat (3) @(negedge ref_clk);
      check({pin_j5.oe, pin_j5.o, spi_mosi, spi_sclk, spi_cs_n}, {1'b1, r[0], r[1], r[2], 1'b0});
      wrap_up();
   end
endmodule
